// ==== inc/tres_pkg.sv ====
// package for the translation result register block
// assumes a single clock domain; walker and bus share clk
package tres_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte addresses on the bus)
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_RES_LO = 12'h000; // result bits 31:0
   localparam logic [11:0] OFF_RES_HI = 12'h004; // result bits 63:32
   localparam logic [11:0] OFF_CTRL   = 12'h008; // layout and options
   localparam logic [11:0] OFF_STAT   = 12'h00C; // completion status

   // ----------------------------------------------------------------
   // result field positions
   // ----------------------------------------------------------------
   localparam int F_BIT    = 0;  // fault marker
   localparam int SS_BIT   = 1;  // supersection flag
   localparam int OUT_LO   = 2;  // outer attributes 3:2
   localparam int OUT_HI   = 3;
   localparam int INN_LO   = 4;  // inner attributes 6:4
   localparam int INN_HI   = 6;
   localparam int SH_BIT   = 7;  // short shareable
   localparam int VEND_BIT = 8;  // short vendor bit
   localparam int NS_BIT   = 9;  // security attribute
   localparam int NOS_BIT  = 10; // outer share clear
   localparam int LVEND    = 10; // long vendor bit
   localparam int PA_LO    = 12; // address low bit
   localparam int SD_PA_HI = 31; // short address top
   localparam int SS_EX_LO = 16; // supersection extension 23:16
   localparam int SS_EX_HI = 23;
   localparam int SS_PA_LO = 24; // supersection address 31:24
   localparam int LD_PA_HI = 47; // long address top
   localparam int PA_TOP   = 39; // highest stored long address bit
   localparam int ATTR_LO  = 56; // memory attributes 63:56
   localparam int ATTR_HI  = 63;
   localparam int LSH_LO   = 7;  // coherence domain 8:7
   localparam int LSH_HI   = 8;

   // fault layout flags
   localparam int TF_BIT  = 1;
   localparam int AFF_BIT = 2;
   localparam int PF_BIT  = 3;
   localparam int EF_BIT  = 4;
   localparam int MC_BIT  = 5;
   localparam int LK_BIT  = 6;
   localparam int ASF_BIT = 7;

   // ----------------------------------------------------------------
   // control and status fields, reset values
   // ----------------------------------------------------------------
   localparam int ST_VALID  = 0;  // a result has been written
   localparam int ST_FAULT  = 1;  // last completion faulted
   localparam int ST_CNT_LO = 8;  // completion counter 15:8
   localparam int ST_CNT_HI = 15;
   localparam logic [5:0]  CTRL_RST = 6'h3E;
   localparam logic [63:0] RES_RST  = 64'h0000_0000_0000_0000;

   // attribute encodings
   localparam logic [2:0] INN_WB_NA = 3'h7;
   localparam logic [2:0] INN_WT    = 3'h6;
   localparam logic [2:0] INN_WB_WA = 3'h5;
   localparam logic [2:0] INN_DEV   = 3'h3;
   localparam logic [2:0] INN_SO    = 3'h1;
   localparam logic [2:0] INN_NC    = 3'h0;
   localparam logic [1:0] OUT_WB_NA = 2'h0;
   localparam logic [1:0] OUT_WT    = 2'h2;
   localparam logic [1:0] OUT_WB_WA = 2'h1;
   localparam logic [1:0] OUT_NC    = 2'h3;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic addr_size_fault;
      logic lock_fault;
      logic multi_hit_fault;
      logic external_fault;
      logic permission_fault;
      logic access_flag_fault;
      logic translation_fault;
   } tres_fault_t;

   typedef struct packed {
      logic        valid;            // one-cycle completion
      logic        fault;            // walk aborted
      logic        supersection;
      logic        outer_share;      // memory is outer shareable
      logic        security_attr;
      logic        vendor_bit;
      logic        shareable;
      logic [2:0]  inner;
      logic [1:0]  outer;
      logic [7:0]  mem_attributes;
      logic [1:0]  coherence_domain;
      logic [47:0] phys_addr;
      tres_fault_t faults;
   } tres_done_t;

   typedef struct packed {
      logic ext_ok;       // bit 5
      logic multi_ok;     // bit 4
      logic lock_ok;      // bit 3
      logic secure_bank;  // bit 2
      logic distinguish;  // bit 1
      logic long_scheme;  // bit 0
   } tres_cfg_t;

   // bits that hold storage for a layout; the rest read zero
   function automatic logic [63:0] tres_keep(input tres_cfg_t c,
                                            input logic fault);
      logic [63:0] k;
      k = '1;
      if (fault)
      begin
         k[LK_BIT] = c.lock_ok;
         k[MC_BIT] = c.multi_ok;
         k[EF_BIT] = c.ext_ok;
      end
      else if (c.long_scheme)
      begin
         k[55:48]           = '0;
         k[LD_PA_HI:PA_TOP+1] = '0;
         k[INN_HI:SS_BIT]   = '0;
         k[F_BIT]           = 1'b0;
      end
      else
      begin
         k[63:32]  = '0;
         k[11]     = 1'b0;
         k[F_BIT]  = 1'b0;
      end
      return k;
   endfunction

endpackage

// ==== test/tres_testbench.sv ====
// self-checking bench for the translation result register
// assumes apb slave with pready in the access cycle; ce is held high
`timescale 1ns/1ps
module testbench
   import tres_pkg::*;
;
   // ----------------------------------------------------------------
   // stimulus and observation
   // ----------------------------------------------------------------
   logic        clk;        // 20 MHz bench clock
   logic        resetn;     // sync reset, active low
   logic        ce;         // clock enable, tied high
   logic        psel;       // apb select
   logic        penable;    // apb access phase
   logic        pwrite;     // apb direction
   logic [11:0] paddr;      // apb byte address
   logic [31:0] pwdata;     // apb write data
   logic [31:0] prdata;     // apb read data
   logic        pready;     // apb answer
   logic        pslverr;    // apb error
   tres_done_t  done;       // walker completion
   logic [63:0] result;     // live result register
   logic        result_fault; // result bit 0
   int          bad_count;  // mismatches
   int          num_checks; // comparisons made
   int          cycles;     // timeout counter
   logic [31:0] rd;         // read data of last transfer
   logic        err;        // error of last transfer
   logic [5:0]  q_cfg[$];   // table: control word
   tres_done_t  nxt;        // completion staged with valid set
   tres_done_t  q_done[$];  // table: completion
   logic [63:0] q_exp[$];   // table: expected word

`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin bad_count++; \
   $display("BAD %s exp %h got %h", nm, ex, gt); end end

   tres_result u_dut
   (
      .clk          (clk),
      .resetn       (resetn),
      .ce           (ce),
      .psel         (psel),
      .penable      (penable),
      .pwrite       (pwrite),
      .paddr        (paddr),
      .pwdata       (pwdata),
      .prdata       (prdata),
      .pready       (pready),
      .pslverr      (pslverr),
      .done         (done),
      .result       (result),
      .result_fault (result_fault)
   );

   // ----------------------------------------------------------------
   // clock, timeout and verdict
   // ----------------------------------------------------------------
   initial clk = 1'b0;
   always #25 clk = ~clk;

   // a hang counts as a mismatch and ends the run
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // bus and completion drivers
   // ----------------------------------------------------------------
   // one apb transfer; held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // answer and data are taken at the rising edge that sees pready
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // one-cycle completion pulse, result checked once it lands
   task automatic fire(input tres_done_t d);
      tres_done_t dv;
      dv       = d;
      dv.valid = 1'b1;
      @(posedge clk);
      done <= dv;
      @(posedge clk);
      done.valid <= 1'b0;
      @(negedge clk);
   endtask

   function automatic tres_done_t mk(input logic f, ss, os, sa, vb, sh,
      input logic [2:0] inn, input logic [1:0] outr, input logic [7:0] ma,
      input logic [1:0] cd, input logic [47:0] pa, input logic [6:0] flt);
      tres_done_t d;
      d = '0;
      d.fault = f;
      d.supersection = ss;
      d.outer_share = os;
      d.security_attr = sa;
      d.vendor_bit = vb;
      d.shareable = sh;
      d.inner = inn;
      d.outer = outr;
      d.mem_attributes = ma;
      d.coherence_domain = cd;
      d.phys_addr = pa;
      d.faults = flt;
      return d;
   endfunction

   task automatic row(input logic [5:0] c, input tres_done_t d, input logic [63:0] e);
      q_cfg.push_back(c);
      q_done.push_back(d);
      q_exp.push_back(e);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      resetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      done = '0;
      bad_count = 0;
      num_checks = 0;
      cycles = 0;
      // short layouts: every inner and outer code, both share readings
      row(6'h3E, mk(0,0,0,1,0,1,INN_WB_NA,OUT_WT,8'h00,2'h0,48'h1234_5678_9ABC,0),
          64'h0000_0000_5678_96F8);
      row(6'h3E, mk(0,1,1,0,1,0,INN_DEV,OUT_WB_WA,8'h00,2'h0,48'hAB12_3456_7000,0),
          64'h0000_0000_3412_0136);
      row(6'h38, mk(0,0,0,1,0,1,INN_WB_WA,OUT_NC,8'h00,2'h0,48'h0000_FFFF_F000,0),
          64'h0000_0000_FFFF_F0DC);
      row(6'h3E, mk(0,0,1,0,0,0,INN_WT,OUT_WB_NA,8'h00,2'h0,48'h0000_0000_1000,0),
          64'h0000_0000_0000_1060);
      row(6'h3E, mk(0,0,1,0,0,0,INN_SO,OUT_WB_NA,8'h00,2'h0,48'h0,0),
          64'h0000_0000_0000_0010);
      row(6'h3E, mk(0,0,1,0,0,0,INN_NC,OUT_NC,8'h00,2'h0,48'h0,0),
          64'h0000_0000_0000_000C);
      // long layouts: attributes, address top, reserved fields clear
      row(6'h3F, mk(0,1,0,1,1,1,3'h7,2'h3,8'hA5,2'h2,48'hFFFF_FFFF_F123,0),
          64'hA500_00FF_FFFF_F700);
      row(6'h3B, mk(0,0,0,1,0,0,3'h0,2'h0,8'h44,2'h3,48'h0012_3456_7000,0),
          64'h4400_0012_3456_7180);
      // fault layout: all flags, optional flags off, then one at a time
      row(6'h3E, mk(1,1,1,1,1,1,3'h7,2'h3,8'hFF,2'h3,48'hFFFF_FFFF_FFFF,7'h7F),
          64'h0000_0000_0000_00FF);
      row(6'h07, mk(1,0,0,0,0,0,3'h0,2'h0,8'h00,2'h0,48'h0,7'h7F), 64'h8F);
      for (int i = 0; i < 7; i++)
         row(6'h3F, mk(1,0,0,0,0,0,3'h0,2'h0,8'h00,2'h0,48'h0,7'h01 << i),
             64'h1 | (64'h2 << i));
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      `CHK("result after reset", 64'h0, result)
      apb(0, OFF_CTRL, 0);
      `CHK("ctrl after reset", 32'h3E, rd)
      for (int i = 0; i < q_exp.size(); i++)
      begin
         apb(1, OFF_CTRL, {26'h0, q_cfg[i]});
         fire(q_done[i]);
         `CHK("result word", q_exp[i], result)
         `CHK("fault marker", q_exp[i][0], result_fault)
         apb(0, OFF_RES_LO, 0);
         `CHK("read low", q_exp[i][31:0], rd)
         apb(0, OFF_RES_HI, 0);
         `CHK("read high", q_exp[i][63:32], rd)
      end
      apb(1, OFF_STAT, 32'h0);
      apb(0, OFF_STAT, 0);
      `CHK("status count", 32'h0000_1103, rd)
      // unmapped place refused both ways
      apb(0, 12'h010, 0);
      `CHK("unmapped read err", 1'b1, err)
      `CHK("unmapped read data", 32'h0, rd)
      apb(1, 12'h010, 32'hFFFF_FFFF);
      `CHK("unmapped write err", 1'b1, err)
      // back-to-back completions: the later one owns every bit
      nxt = mk(0,0,0,0,0,1,INN_WT,OUT_WT,8'h00,2'h0,48'hFFFF_F000,0);
      nxt.valid = 1'b1;
      @(posedge clk);
      done <= nxt;
      nxt = mk(1,0,0,0,0,0,3'h0,2'h0,8'h00,2'h0,48'h0,7'h01);
      nxt.valid = 1'b1;
      @(posedge clk);
      done <= nxt;
      @(posedge clk);
      done.valid <= 1'b0;
      @(negedge clk);
      `CHK("second completion", 64'h3, result)
      // software writes pass through the layout storage mask
      apb(1, OFF_CTRL, 32'h3E);
      apb(1, OFF_RES_LO, 32'hFFFF_FFFE);
      @(negedge clk);
      `CHK("short write low", 64'h0000_0000_FFFF_F7FE, result)
      apb(1, OFF_RES_HI, 32'hFFFF_FFFF);
      @(negedge clk);
      `CHK("short write high", 64'h0000_0000_FFFF_F7FE, result)
      apb(1, OFF_CTRL, 32'h3F);
      apb(1, OFF_RES_HI, 32'hFFFF_FFFF);
      @(negedge clk);
      `CHK("long write high", 64'hFF00_00FF_FFFF_F780, result)
      // second reset in mid-run
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      `CHK("result after reset", 64'h0, result)
      apb(0, OFF_RES_HI, 0);
      `CHK("high snapshot reset", 32'h0, rd)
      apb(0, OFF_STAT, 0);
      `CHK("status reset", 32'h0, rd)
      results();
   end
endmodule

// ==== verilog/tres_format.sv ====
// builds the 64-bit result word from one completed walk
// assumes inputs are steady in the cycle they are sampled
`timescale 1ns/1ps
module tres_format
   import tres_pkg::*;
(
   input  tres_done_t  done,
   input  tres_cfg_t   cfg,
   output logic [63:0] word
);

   logic [63:0] w; // unmasked layout

   // ----------------------------------------------------------------
   // layout selection
   // ----------------------------------------------------------------
   always_comb
   begin
      w = '0;
      if (done.fault)
      begin
         // one fault layout whatever the scheme
         w[F_BIT]   = 1'b1;
         w[ASF_BIT] = done.faults.addr_size_fault;
         w[LK_BIT]  = done.faults.lock_fault;
         w[MC_BIT]  = done.faults.multi_hit_fault;
         w[EF_BIT]  = done.faults.external_fault;
         w[PF_BIT]  = done.faults.permission_fault;
         w[AFF_BIT] = done.faults.access_flag_fault;
         w[TF_BIT]  = done.faults.translation_fault;
      end
      else if (cfg.long_scheme)
      begin
         w[ATTR_HI:ATTR_LO]  = done.mem_attributes;
         w[LD_PA_HI:PA_LO]   = done.phys_addr[47:12];
         w[NS_BIT]  = cfg.secure_bank & done.security_attr;
         w[LSH_HI:LSH_LO]    = done.coherence_domain;
         w[LVEND]            = done.vendor_bit;
      end
      else
      begin
         // supersection moves address bits 39:32 down
         if (done.supersection)
         begin
            w[SD_PA_HI:SS_PA_LO] = done.phys_addr[31:24];
            w[SS_EX_HI:SS_EX_LO] = done.phys_addr[39:32];
         end
         else
         begin
            w[SD_PA_HI:PA_LO] = done.phys_addr[31:12];
         end
         w[SS_BIT]  = done.supersection;
         // without the distinction the bit is kept at zero
         w[NOS_BIT] = cfg.distinguish & ~done.outer_share;
         w[NS_BIT]  = cfg.secure_bank & done.security_attr;
         w[VEND_BIT] = done.vendor_bit;
         w[SH_BIT]  = done.shareable;
         w[INN_HI:INN_LO] = done.inner;
         w[OUT_HI:OUT_LO] = done.outer;
      end
      // success leaves bit 0 clear via the keep mask
      word = w & tres_keep(cfg, done.fault);
   end

endmodule

// ==== verilog/tres_result.sv ====
// translation result register with its bus slave
// assumes walker completion arrives on clk; software uses apb
`timescale 1ns/1ps
module tres_result
   import tres_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire tres_done_t  done,
   output logic      [63:0] result,
   output logic             result_fault
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   typedef enum logic {TRES_IDLE, TRES_ACC} tres_bus_t;

   tres_bus_t   bus_q, bus_d;       // bus phase tracker
   logic [31:0] rdata_q, rdata_d;   // registered read data
   logic        rdy_q, rdy_d;       // registered ready
   logic        err_q, err_d;       // registered error
   logic [31:0] shadow_q, shadow_d; // upper word caught on low read
   logic [63:0] res_q, res_d;       // the result register
   tres_cfg_t   cfg_q, cfg_d;       // control register
   logic        valid_q, valid_d;   // any result written
   logic        flt_q, flt_d;       // last completion faulted
   logic [7:0]  cnt_q, cnt_d;       // completions seen
   logic [63:0] fmt_word;           // formatted completion
   logic        setup;              // setup phase seen
   logic        wr_go;              // write takes effect
   logic [63:0] wr_word;            // result after a software write
   logic        done_go;            // completion accepted

   // ----------------------------------------------------------------
   // formatter
   // ----------------------------------------------------------------
   tres_format u_format
   (
      .done (done),
      .cfg  (cfg_q),
      .word (fmt_word)
   );

   // decode of the four words
   function automatic logic mapped(input logic [11:0] a);
      return (a == OFF_RES_LO) || (a == OFF_RES_HI) ||
             (a == OFF_CTRL)   || (a == OFF_STAT);
   endfunction

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   assign setup = psel && !penable;
   assign wr_go = (bus_q == TRES_ACC) && psel && penable && rdy_q
                  && pwrite && !err_q;

   // read data is captured in setup so prdata stays a flop output
   always_comb
   begin
      bus_d    = bus_q;
      rdata_d  = rdata_q;
      rdy_d    = 1'b0;
      err_d    = 1'b0;
      shadow_d = shadow_q;
      case (bus_q)
         TRES_IDLE:
         begin
            if (setup)
            begin
               bus_d   = TRES_ACC;
               rdy_d   = 1'b1;
               err_d   = !mapped(paddr);
               rdata_d = '0;
               if (!pwrite)
               begin
                  case (paddr)
                     OFF_RES_LO:
                     begin
                        // snapshot pairs the two halves
                        rdata_d  = res_q[31:0];
                        shadow_d = res_q[63:32];
                     end
                     OFF_RES_HI: rdata_d = shadow_q;
                     OFF_CTRL:   rdata_d = {26'h0, cfg_q};
                     OFF_STAT:
                     begin
                        rdata_d[ST_VALID] = valid_q;
                        rdata_d[ST_FAULT] = flt_q;
                        rdata_d[ST_CNT_HI:ST_CNT_LO] = cnt_q;
                     end
                     default:    rdata_d = '0;
                  endcase
               end
            end
         end
         TRES_ACC:
         begin
            // transfer ends at this edge; hold errors until then
            rdy_d = 1'b0;
            err_d = 1'b0;
            bus_d = TRES_IDLE;
         end
         default:
         begin
            bus_d = TRES_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         bus_q    <= TRES_IDLE;
         rdata_q  <= '0;
         rdy_q    <= 1'b0;
         err_q    <= 1'b0;
         shadow_q <= '0;
      end
      else if (ce)
      begin
         bus_q    <= bus_d;
         rdata_q  <= rdata_d;
         rdy_q    <= rdy_d;
         err_q    <= err_d;
         shadow_q <= shadow_d;
      end
   end

   // error flag only stands in the access cycle
   assign prdata  = rdata_q;
   assign pready  = rdy_q;
   assign pslverr = err_q;

   // ----------------------------------------------------------------
   // result register and status
   // ----------------------------------------------------------------
   // a software write applies the layout's storage mask
   always_comb
   begin
      wr_word = res_q;
      if (paddr == OFF_RES_LO)
      begin
         wr_word[31:0] = pwdata;
      end
      else if (paddr == OFF_RES_HI)
      begin
         wr_word[63:32] = pwdata;
      end
      wr_word = wr_word & tres_keep(cfg_q, wr_word[F_BIT]);
   end

   assign done_go = done.valid;

   // completion beats a software write in the same cycle
   always_comb
   begin
      res_d   = res_q;
      cfg_d   = cfg_q;
      valid_d = valid_q;
      flt_d   = flt_q;
      cnt_d   = cnt_q;
      if (wr_go && (paddr == OFF_CTRL))
      begin
         cfg_d = pwdata[5:0];
      end
      if (wr_go && ((paddr == OFF_RES_LO) || (paddr == OFF_RES_HI)))
      begin
         res_d   = wr_word;
         valid_d = 1'b1;
      end
      if (done_go)
      begin
         // all 64 bits land on one edge
         res_d   = fmt_word;
         valid_d = 1'b1;
         flt_d   = done.fault;
         cnt_d   = cnt_q + 8'h01;
      end
   end

   // reset value is left open for software; zero is used here
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         res_q   <= RES_RST;
         cfg_q   <= CTRL_RST;
         valid_q <= 1'b0;
         flt_q   <= 1'b0;
         cnt_q   <= '0;
      end
      else if (ce)
      begin
         res_q   <= res_d;
         cfg_q   <= cfg_d;
         valid_q <= valid_d;
         flt_q   <= flt_d;
         cnt_q   <= cnt_d;
      end
   end

   assign result       = res_q;
   assign result_fault = res_q[F_BIT];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   short_addr_a: assert property (
      ce && done.valid && !done.fault && !cfg_q.long_scheme
      && !done.supersection |=> res_q[SD_PA_HI:PA_LO] ==
      $past(done.phys_addr[31:12]) && res_q[63:32] == 32'h0)
      else $error("short address not stored");

   outer_share_a: assert property (
      ce && done.valid && !done.fault && !cfg_q.long_scheme
      |=> res_q[NOS_BIT] ==
      ($past(cfg_q.distinguish) && !$past(done.outer_share)))
      else $error("outer share bit wrong");

   shareable_a: assert property (
      ce && done.valid && !done.fault && !cfg_q.long_scheme
      |=> res_q[SH_BIT] == $past(done.shareable))
      else $error("shareable bit wrong");

   super_map_a: assert property (
      ce && done.valid && !done.fault && !cfg_q.long_scheme
      && done.supersection |=> res_q[SS_BIT]
      && res_q[SS_EX_HI:SS_EX_LO] == $past(done.phys_addr[39:32])
      && res_q[15:12] == 4'h0)
      else $error("supersection map wrong");

   ok_fault_a: assert property (
      ce && done.valid && !done.fault |=> !res_q[F_BIT])
      else $error("success left fault bit set");

   long_attr_a: assert property (
      ce && done.valid && !done.fault && cfg_q.long_scheme
      |=> res_q[ATTR_HI:ATTR_LO] == $past(done.mem_attributes)
      && res_q[55:48] == 8'h00 && res_q[PA_TOP+8:PA_TOP+1] == 8'h00)
      else $error("long layout attributes wrong");

   abort_mark_a: assert property (
      ce && done.valid && done.fault |=> res_q[F_BIT] && flt_q)
      else $error("abort not marked");

   fault_flags_a: assert property (
      ce && done.valid && done.fault |=>
      res_q[PF_BIT] == $past(done.faults.permission_fault)
      && res_q[TF_BIT] == $past(done.faults.translation_fault)
      && res_q[AFF_BIT] == $past(done.faults.access_flag_fault)
      && res_q[ASF_BIT] == $past(done.faults.addr_size_fault))
      else $error("fault flags wrong");

   lock_wi_a: assert property (
      res_q[F_BIT] && !cfg_q.lock_ok && $changed(res_q) |-> !res_q[LK_BIT])
      else $error("lock flag stored while absent");

   read_pair_a: assert property (
      ce && setup && !pwrite && paddr == OFF_RES_LO
      |=> shadow_q == $past(res_q[63:32]) ##0 pready)
      else $error("upper word not snapped");

endmodule
